//--- hdl/hpc_consts.svh
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// Byte offsets of the configuration bytes
`define HPC_ADDR_SELF_MASK    8'h09
`define HPC_ADDR_BUS_MASK     8'h0a
`define HPC_ADDR_SELF_POWER   8'h0b
`define HPC_ADDR_BUS_POWER    8'h0c
`define HPC_ADDR_SELF_CURRENT 8'h0d
`define HPC_ADDR_BUS_CURRENT  8'h0e
`define HPC_ADDR_POWER_GOOD   8'h0f
`define HPC_ADDR_FIRST        8'h09
`define HPC_ADDR_LAST         8'h0f

// Index of each byte in the storage array
`define HPC_IDX_SELF_MASK     3'h0
`define HPC_IDX_BUS_MASK      3'h1
`define HPC_IDX_SELF_POWER    3'h2
`define HPC_IDX_BUS_POWER     3'h3
`define HPC_IDX_SELF_CURRENT  3'h4
`define HPC_IDX_BUS_CURRENT   3'h5
`define HPC_IDX_POWER_GOOD    3'h6
`define HPC_NUM_REGS          7

// Field layout of the port disable masks
`define HPC_PORT_LSB          1
`define HPC_PORT_MSB          4
`define HPC_PORT_BITS         8'h1e

// Reset values
`define HPC_RESET_BYTE        8'h00
`define HPC_CURRENT_DEFAULT   8'h32
`define HPC_CURRENT_DEF_MA    9'h064

// Scale of one count: 2 mA and 2 ms
`define HPC_UNIT_MA           9'h002
`define HPC_UNIT_MS           9'h002

`endif

//--- hdl/hpc_pkg.sv
package hpc_pkg;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } hpc_wr_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } hpc_rd_req_t;

   typedef struct packed {
      logic       self_powered;
      logic [3:0] port_disable;
      logic [7:0] total_power;
      logic [7:0] ctrl_current;
      logic [7:0] power_good_delay;
   } hpc_power_cfg_t;

endpackage

//--- hdl/hpc_config_bytes.sv
// Notes on behaviour
// - Self mode uses self mask, bits 4:1.
// - Bus mode uses bus mask, bits 4:1.
// - Mask bits 7:5 and 0 held zero.
// - Self total power counts 2 mA each.
// - Bus total power counts 2 mA each.
// - Count of 50 means 100 mA.
// - Self controller current counts 2 mA each.
// - Bus controller current counts 2 mA each.
// - Both controller currents reset to 50.
// - Power good delay counts 2 ms each.
// - Select bit or pin picks self/bus set.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_config_bytes
   import hpc_pkg::*;
(
   input  wire logic           i_clk,
   input  wire logic           i_rst,
   input  wire logic           i_ce,
   input  wire hpc_wr_req_t    i_wr,
   input  wire hpc_rd_req_t    i_rd,
   input  wire logic           i_power_source_select,
   input  wire logic           i_dynamic_enable,
   input  wire logic           i_self_pwr_pin,
   output logic [7:0]          o_rdata,
   output logic                o_rvalid,
   output hpc_power_cfg_t      o_cfg,
   output logic [8:0]          o_total_power_ma,
   output logic [8:0]          o_ctrl_current_ma,
   output logic [8:0]          o_power_good_ms
);

   logic           pin_s1_q;
   logic           pin_s2_q;
   logic           pin_s1_d;
   logic           pin_s2_d;
   logic [7:0]     regs_q [`HPC_NUM_REGS];
   logic [7:0]     regs_d [`HPC_NUM_REGS];
   logic [7:0]     wr_off;
   logic [7:0]     rd_off;
   logic           wr_hit;
   logic           rd_hit;
   logic           self_mode;
   hpc_power_cfg_t cfg_d;
   logic [8:0]     total_ma_d;
   logic [8:0]     current_ma_d;
   logic [8:0]     delay_ms_d;
   logic [7:0]     rdata_d;
   logic           rvalid_d;

   // Self-power sense pin synchroniser
   always_comb begin
      pin_s1_d = pin_s1_q;
      pin_s2_d = pin_s2_q;
      if (i_ce) begin
         pin_s1_d = i_self_pwr_pin;
         pin_s2_d = pin_s1_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
      end
   end

   // Configuration byte storage
   always_comb begin
      wr_off = i_wr.addr - `HPC_ADDR_FIRST;
      wr_hit = i_ce && i_wr.valid && (i_wr.addr >= `HPC_ADDR_FIRST)
               && (i_wr.addr <= `HPC_ADDR_LAST);
      for (int i = 0; i < `HPC_NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
         if (wr_hit && (wr_off[2:0] == 3'(i))) begin
            regs_d[i] = i_wr.data;
         end
      end
      // Reserved mask bits never stored
      regs_d[`HPC_IDX_SELF_MASK] = regs_d[`HPC_IDX_SELF_MASK]
                                   & `HPC_PORT_BITS;
      regs_d[`HPC_IDX_BUS_MASK]  = regs_d[`HPC_IDX_BUS_MASK]
                                   & `HPC_PORT_BITS;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < `HPC_NUM_REGS; i++) begin
            regs_q[i] <= `HPC_RESET_BYTE;
         end
         regs_q[`HPC_IDX_SELF_CURRENT] <= `HPC_CURRENT_DEFAULT;
         regs_q[`HPC_IDX_BUS_CURRENT]  <= `HPC_CURRENT_DEFAULT;
      end else begin
         regs_q <= regs_d;
      end
   end

   // Selected configuration towards the hub core
   always_comb begin
      self_mode = i_dynamic_enable ? pin_s2_q
                                   : i_power_source_select;
      cfg_d = o_cfg;
      total_ma_d = o_total_power_ma;
      current_ma_d = o_ctrl_current_ma;
      delay_ms_d = o_power_good_ms;
      if (i_ce) begin
         cfg_d.self_powered = self_mode;
         if (self_mode) begin
            cfg_d.port_disable = regs_q[`HPC_IDX_SELF_MASK]
                                 [`HPC_PORT_MSB:`HPC_PORT_LSB];
            cfg_d.total_power  = regs_q[`HPC_IDX_SELF_POWER];
            cfg_d.ctrl_current = regs_q[`HPC_IDX_SELF_CURRENT];
         end else begin
            cfg_d.port_disable = regs_q[`HPC_IDX_BUS_MASK]
                                 [`HPC_PORT_MSB:`HPC_PORT_LSB];
            cfg_d.total_power  = regs_q[`HPC_IDX_BUS_POWER];
            cfg_d.ctrl_current = regs_q[`HPC_IDX_BUS_CURRENT];
         end
         cfg_d.power_good_delay = regs_q[`HPC_IDX_POWER_GOOD];
         // Linear scale, 50 counts give 100 mA
         total_ma_d   = 9'(cfg_d.total_power) * `HPC_UNIT_MA;
         current_ma_d = 9'(cfg_d.ctrl_current) * `HPC_UNIT_MA;
         delay_ms_d   = 9'(cfg_d.power_good_delay)
                        * `HPC_UNIT_MS;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cfg             <= '0;
         o_total_power_ma  <= '0;
         o_ctrl_current_ma <= '0;
         o_power_good_ms   <= '0;
      end else begin
         o_cfg             <= cfg_d;
         o_total_power_ma  <= total_ma_d;
         o_ctrl_current_ma <= current_ma_d;
         o_power_good_ms   <= delay_ms_d;
      end
   end

   // Read port, unmapped offsets answer zero
   always_comb begin
      rd_off = i_rd.addr - `HPC_ADDR_FIRST;
      rd_hit = (i_rd.addr >= `HPC_ADDR_FIRST)
               && (i_rd.addr <= `HPC_ADDR_LAST);
      rdata_d = o_rdata;
      rvalid_d = o_rvalid;
      if (i_ce) begin
         rvalid_d = i_rd.valid;
         if (i_rd.valid) begin
            rdata_d = `HPC_RESET_BYTE;
            for (int i = 0; i < `HPC_NUM_REGS; i++) begin
               if (rd_hit && (rd_off[2:0] == 3'(i))) begin
                  rdata_d = regs_q[i];
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata  <= '0;
         o_rvalid <= 1'b0;
      end else begin
         o_rdata  <= rdata_d;
         o_rvalid <= rvalid_d;
      end
   end

   self_mask_sel_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && $past(self_mode)
      |-> o_cfg.port_disable == $past(regs_q[`HPC_IDX_SELF_MASK]
                                      [`HPC_PORT_MSB:`HPC_PORT_LSB]))
      else $error("Self mask not applied in self mode");

   bus_mask_sel_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(self_mode)
      |-> o_cfg.port_disable == $past(regs_q[`HPC_IDX_BUS_MASK]
                                      [`HPC_PORT_MSB:`HPC_PORT_LSB]))
      else $error("Bus mask not applied in bus mode");

   mask_reserved_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && i_wr.valid && (i_wr.addr == `HPC_ADDR_SELF_MASK
                             || i_wr.addr == `HPC_ADDR_BUS_MASK)
      |=> (regs_q[`HPC_IDX_SELF_MASK] & ~`HPC_PORT_BITS) == 8'h00
          && (regs_q[`HPC_IDX_BUS_MASK] & ~`HPC_PORT_BITS) == 8'h00
          && ($past(i_wr.data) & `HPC_PORT_BITS)
             == (($past(i_wr.addr) == `HPC_ADDR_SELF_MASK)
                 ? regs_q[`HPC_IDX_SELF_MASK]
                 : regs_q[`HPC_IDX_BUS_MASK]))
      else $error("Reserved mask bits stored or mask lost");

   total_power_ma_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_rst)
      |-> o_total_power_ma == ($past(self_mode)
          ? 9'($past(regs_q[`HPC_IDX_SELF_POWER]))
          : 9'($past(regs_q[`HPC_IDX_BUS_POWER]))) * `HPC_UNIT_MA)
      else $error("Total power not scaled by 2 mA");

   bus_power_sel_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(self_mode)
      |-> o_cfg.total_power == $past(regs_q[`HPC_IDX_BUS_POWER]))
      else $error("Bus total power not selected");

   fifty_is_100ma_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_cfg.ctrl_current == `HPC_CURRENT_DEFAULT
      |-> o_ctrl_current_ma == `HPC_CURRENT_DEF_MA)
      else $error("Count of 50 not reported as 100 mA");

   ctrl_current_sel_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_rst)
      |-> o_cfg.ctrl_current == ($past(self_mode)
          ? $past(regs_q[`HPC_IDX_SELF_CURRENT])
          : $past(regs_q[`HPC_IDX_BUS_CURRENT])))
      else $error("Controller current from wrong set");

   current_default_a: assert property (
      @(posedge i_clk)
      $past(i_rst) && !i_rst
      |-> regs_q[`HPC_IDX_SELF_CURRENT] == `HPC_CURRENT_DEFAULT
          && regs_q[`HPC_IDX_BUS_CURRENT] == `HPC_CURRENT_DEFAULT)
      else $error("Controller current default not 50");

   delay_ms_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_rst)
      |-> o_power_good_ms
          == 9'($past(regs_q[`HPC_IDX_POWER_GOOD])) * `HPC_UNIT_MS)
      else $error("Power good delay not scaled by 2 ms");

   select_bit_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_dynamic_enable) && !$past(i_rst)
      |-> o_cfg.self_powered == $past(i_power_source_select))
      else $error("Select bit ignored without dynamic switching");

   select_pin_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && $past(i_ce, 2) && $past(i_ce, 3)
      && $past(i_dynamic_enable)
      && !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
      |-> o_cfg.self_powered == $past(i_self_pwr_pin, 3))
      else $error("Sense pin not used with dynamic switching");

   read_back_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && i_rd.valid && i_rd.addr == `HPC_ADDR_POWER_GOOD
      |=> o_rvalid && o_rdata == $past(regs_q[`HPC_IDX_POWER_GOOD]))
      else $error("Read back differs from stored byte");

   freeze_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !$past(i_ce) |-> $stable(o_cfg) && $stable(o_rvalid))
      else $error("State moved with clock enable low");

   self_power_sel_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && $past(self_mode) && !$past(i_rst)
      |-> o_cfg.total_power == $past(regs_q[`HPC_IDX_SELF_POWER]))
      else $error("Self total power not selected");

   current_ma_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_rst)
      |-> o_ctrl_current_ma == ($past(self_mode)
          ? 9'($past(regs_q[`HPC_IDX_SELF_CURRENT]))
          : 9'($past(regs_q[`HPC_IDX_BUS_CURRENT]))) * `HPC_UNIT_MA)
      else $error("Controller current not scaled by 2 mA");

   delay_shared_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $past(i_ce) && !$past(i_rst)
      |-> o_cfg.power_good_delay == $past(regs_q[`HPC_IDX_POWER_GOOD]))
      else $error("Power good delay not passed on unchanged");

   mask_read_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_ce && i_rd.valid && (i_rd.addr == `HPC_ADDR_SELF_MASK
                             || i_rd.addr == `HPC_ADDR_BUS_MASK)
      |=> o_rvalid && (o_rdata & ~`HPC_PORT_BITS) == 8'h00)
      else $error("Reserved mask bits read back as one");

   freeze_out_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !$past(i_ce) |-> $stable(o_total_power_ma) && $stable(o_rdata)
          && $stable(o_ctrl_current_ma) && $stable(o_power_good_ms))
      else $error("Scaled outputs moved with clock enable low");

endmodule

`default_nettype wire

//--- dv/hpc_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"
module hpc_loader
   import hpc_pkg::*;
(
   input  wire logic        i_clk,
   output var  hpc_wr_req_t o_wr,
   output var  hpc_rd_req_t o_rd
);
   initial begin
      o_wr = '0;
      o_rd = '0;
   end
   // Called just after a rising edge; returns just after the next one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == `HPC_ADDR_SELF_MASK || a == `HPC_ADDR_BUS_MASK) begin
         v[0] = 1'b0;
      end
      if (a == `HPC_ADDR_SELF_POWER || a == `HPC_ADDR_SELF_CURRENT) begin
         if (v > `HPC_CURRENT_DEFAULT) v = `HPC_CURRENT_DEFAULT;
      end
      o_rd.valid = 1'b0;
      o_wr = '{valid: 1'b1, addr: a, data: v};
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      o_wr.valid = 1'b0;
      o_rd = '{valid: 1'b1, addr: a};
      @(posedge i_clk);
      #1;
   endtask
   task automatic quiet();
      o_wr.valid = 1'b0;
      o_rd.valid = 1'b0;
      @(posedge i_clk);
      #1;
   endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import hpc_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } hpc_row_t;
   logic           clk, rst, ce, sel, dyn, pin;
   hpc_wr_req_t    wr;
   hpc_rd_req_t    rd;
   logic [7:0]     rdata;
   logic           rvalid;
   hpc_power_cfg_t cfg;
   logic [8:0]     pw_ma, cc_ma, dl_ms;
   int             n_errors, cmp_count;
   hpc_row_t       rows [10] = '{
      '{8'h09, 8'hff, 8'h1e}, '{8'h0a, 8'h2b, 8'h0a},
      '{8'h0b, 8'hff, 8'h32}, '{8'h0b, 8'h20, 8'h20},
      '{8'h0c, 8'h7f, 8'h7f}, '{8'h0d, 8'h10, 8'h10},
      '{8'h0e, 8'hc8, 8'hc8}, '{8'h0f, 8'h96, 8'h96},
      '{8'h08, 8'h55, 8'h00}, '{8'h10, 8'h55, 8'h00}};
   hpc_config_bytes u_dut (
      .i_clk                 (clk),
      .i_rst                 (rst),
      .i_ce                  (ce),
      .i_wr                  (wr),
      .i_rd                  (rd),
      .i_power_source_select (sel),
      .i_dynamic_enable      (dyn),
      .i_self_pwr_pin        (pin),
      .o_rdata               (rdata),
      .o_rvalid              (rvalid),
      .o_cfg                 (cfg),
      .o_total_power_ma      (pw_ma),
      .o_ctrl_current_ma     (cc_ma),
      .o_power_good_ms       (dl_ms)
   );
   hpc_loader u_ld (
      .i_clk (clk),
      .o_wr  (wr),
      .o_rd  (rd)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_of_test();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      u_ld.rd(a);
      cmp_byte({rvalid, rdata}, {1'b1, e});
   endtask
   task automatic cmp_cfg(input logic s, input logic [3:0] p,
                          input logic [7:0] t, c, d);
      logic [55:0] exp;
      exp = {s, p, t, c, d, 9'(t) * 9'h002, 9'(c) * 9'h002, 9'(d) * 9'h002};
      cmp_count++;
      if ({cfg, pw_ma, cc_ma, dl_ms} !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time,
                  {cfg, pw_ma, cc_ma, dl_ms}, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end
   initial begin
      n_errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      {ce, sel, dyn, pin} = 4'h8;
      cycles(12);
      cmp_cfg(1'b0, 4'h0, 8'h00, 8'h00, 8'h00);
      rst = 1'b0;
      cycles(2);
      cmp_cfg(1'b0, 4'h0, 8'h00, 8'h32, 8'h00);
      rd_chk(8'h0d, 8'h32);
      rd_chk(8'h0e, 8'h32);
      foreach (rows[i]) begin
         u_ld.wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      u_ld.quiet();
      cycles(3);
      cmp_cfg(1'b0, 4'h5, 8'h7f, 8'hc8, 8'h96);
      sel = 1'b1;
      cycles(2);
      cmp_cfg(1'b1, 4'hf, 8'h20, 8'h10, 8'h96);
      {dyn, pin} = 2'h2;
      cycles(4);
      cmp_cfg(1'b0, 4'h5, 8'h7f, 8'hc8, 8'h96);
      {sel, pin} = 2'h1;
      cycles(4);
      cmp_cfg(1'b1, 4'hf, 8'h20, 8'h10, 8'h96);
      ce = 1'b0;
      u_ld.wr(8'h0f, 8'h11);
      u_ld.quiet();
      ce = 1'b1;
      rd_chk(8'h0f, 8'h96);
      u_ld.quiet();
      cmp_byte({rvalid, rdata}, {1'b0, 8'h96});
      rst = 1'b1;
      cycles(2);
      cmp_cfg(1'b0, 4'h0, 8'h00, 8'h00, 8'h00);
      rst = 1'b0;
      cycles(1);
      rd_chk(8'h0f, 8'h00);
      rd_chk(8'h0d, 8'h32);
      u_ld.quiet();
      end_of_test();
   end
endmodule
`default_nettype wire
